// File: src/tcpu_params.svh
// Constants for the timer/counter/PWM unit: event slots, widths, reset values.
// Assumes inclusion by bare name from the package and the unit.
`ifndef TCPU_PARAMS_SVH
`define TCPU_PARAMS_SVH

// Event slot positions within the event vector
`define TCPU_EV_START 0
`define TCPU_EV_RELOAD 1
`define TCPU_EV_STOP 2
`define TCPU_EV_COUNT 3
`define TCPU_EV_CAPTURE 4
`define TCPU_NUM_EV 5

// Field widths
`define TCPU_PRESC_W 3
`define TCPU_PRESC_CNT_W 7
`define TCPU_SRC_W 4
`define TCPU_DT_W 8

// Documented counter widths of the two instance flavours
`define TCPU_WIDE_CNT 32
`define TCPU_NARROW_CNT 16

// Reset values
`define TCPU_RST_RUNNING 1'h0
`define TCPU_RST_PWM 1'h0
`define TCPU_RST_PEND 1'h0

`endif

// File: src/tcpu_pkg.sv
// Types shared by the timer/counter/PWM unit and its surroundings.
// Assumes tcpu_params.svh is on the include path.
`include "tcpu_params.svh"

package tcpu_pkg;

	// Operating modes
	typedef enum logic [2:0] {
		TCPU_TIMER_CMP,
		TCPU_TIMER_CAP,
		TCPU_QUAD,
		TCPU_PWM,
		TCPU_PWM_PR,
		TCPU_PWM_DT
	} tcpu_mode_t;

	// Counting direction
	typedef enum logic [1:0] {
		TCPU_UP,
		TCPU_DOWN,
		TCPU_UPDOWN
	} tcpu_dir_t;

	// Event sensitivity
	typedef enum logic [1:0] {
		TCPU_RISE,
		TCPU_FALL,
		TCPU_BOTH,
		TCPU_LEVEL
	} tcpu_edge_t;

	// Static configuration, held steady by the owner while running
	typedef struct packed {
		tcpu_mode_t mode;
		tcpu_dir_t dir;
		logic [`TCPU_PRESC_W-1:0] presc;
		tcpu_edge_t [`TCPU_NUM_EV-1:0] edge_sel;
		logic [`TCPU_NUM_EV-1:0][`TCPU_SRC_W-1:0] src_sel;
		logic [`TCPU_DT_W-1:0] dead_time;
		logic kill_lvl;
		logic kill_lvl_n;
	} tcpu_cfg_t;

	// Event pulses towards the outside
	typedef struct packed {
		logic ovf;
		logic unf;
		logic cc;
		logic tc_irq;
		logic cc_irq;
	} tcpu_flags_t;

endpackage : tcpu_pkg

// File: src/tcpu_unit.sv
// Timer/counter/PWM unit: one counter with prescaler, event inputs and PWM outputs.
// Assumes all inputs synchronous to clk and cfg held steady while running.
//
// Function
// R01: Compare, capture, quadrature, PWM, pseudo-random, dead-time modes
// R02: Count up, down or up/down
// R03: Prescaler divides by powers of two to 128
// R04: Compare and period each have buffer copies
// R05: Separate underflow, overflow, capture/compare outputs
// R06: Terminal-count interrupt on overflow or underflow
// R07: Capture copies count and raises cc interrupt
// R08: Count equal to compare raises cc interrupt
// R09: PWM modes drive complementary output
// R10: Selectable source per start/reload/stop/count/capture
// R11: Events respond to rise, fall, both, level
// R12: Kill input forces outputs to set state
// R13: Counter width is a parameter, 32 or 16
// R14: Quadrature counts transitions, direction from phases
// R15: Buffers copy on terminal count or reload
`timescale 1ns/100ps
`include "tcpu_params.svh"

module tcpu_unit import tcpu_pkg::*; #(
	parameter int W = `TCPU_WIDE_CNT, // R13
	parameter int N_TRIG = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire tcpu_cfg_t cfg,
	input wire logic [N_TRIG-1:0] trig_in,
	input wire logic phase_a,
	input wire logic phase_b,
	input wire logic kill,
	input wire logic cmp_buf_wr,
	input wire logic [W-1:0] cmp_buf_data,
	input wire logic per_buf_wr,
	input wire logic [W-1:0] per_buf_data,
	output tcpu_flags_t flags,
	output logic pwm_out,
	output logic pwm_out_n,
	output logic running,
	output logic [W-1:0] count,
	output logic [W-1:0] capture
);

	typedef struct packed {
		logic running;
		logic [`TCPU_PRESC_CNT_W-1:0] presc_cnt;
		logic [W-1:0] count;
		logic going_down;
		logic [W-1:0] cmp;
		logic [W-1:0] cmp_buf;
		logic cmp_pend;
		logic [W-1:0] per;
		logic [W-1:0] per_buf;
		logic per_pend;
		logic [W-1:0] capture;
		logic [`TCPU_NUM_EV-1:0] ev_prev;
		logic qa_prev;
		logic qb_prev;
		logic raw_prev;
		logic [`TCPU_DT_W-1:0] dt_cnt;
		logic pwm;
		logic pwm_n;
		tcpu_flags_t flags;
	} tcpu_state_t;

	tcpu_state_t s;
	tcpu_state_t next_s;
	logic [`TCPU_NUM_EV-1:0] sel;
	logic [`TCPU_NUM_EV-1:0] ev;
	logic tick;
	logic step;
	logic step_up;
	logic wrap;
	logic swap;
	logic raw;
	logic is_pwm;
	logic dt_done;

	// Event detect for one slot; level mode simply passes the level
	function automatic logic evt_hit(input tcpu_edge_t mode, input logic cur, input logic prev);
		case (mode)
			TCPU_RISE: evt_hit = cur & ~prev;
			TCPU_FALL: evt_hit = ~cur & prev;
			TCPU_BOTH: evt_hit = cur ^ prev;
			default: evt_hit = cur;
		endcase
	endfunction : evt_hit

	// Prescaler terminal value for a divide-by-2^sel
	function automatic logic [`TCPU_PRESC_CNT_W-1:0] presc_lim(input logic [`TCPU_PRESC_W-1:0] sel_v);
		presc_lim = `TCPU_PRESC_CNT_W'((8'h01 << sel_v) - 8'h01);
	endfunction : presc_lim

	// Pseudo-random sequence step; zero is escaped so the sequence never locks
	function automatic logic [W-1:0] lfsr_step(input logic [W-1:0] v);
		logic fb;
		fb = v[W-1] ^ v[W-2] ^ v[W-4] ^ v[W-5];
		lfsr_step = (v == '0) ? {{(W-1){1'b0}}, 1'b1} : {v[W-2:0], fb};
	endfunction : lfsr_step

	// Period that is active after a swap at this edge; a reload must see the new one
	function automatic logic [W-1:0] period_after_swap(input logic pend,
		input logic [W-1:0] held, input logic [W-1:0] act);
		period_after_swap = pend ? held : act;
	endfunction : period_after_swap

	// Source selection and event qualification per slot
	always_comb begin
		for (int i = 0; i < `TCPU_NUM_EV; i++) begin
			sel[i] = trig_in[cfg.src_sel[i]]; // R10
			ev[i] = evt_hit(cfg.edge_sel[i], sel[i], s.ev_prev[i]); // R11
		end
	end

	// Next state
	always_comb begin
		next_s = s;
		next_s.flags = '0;
		next_s.ev_prev = sel;
		next_s.qa_prev = phase_a;
		next_s.qb_prev = phase_b;
		tick = 1'b0;
		step = 1'b0;
		step_up = 1'b1;
		wrap = 1'b0;
		is_pwm = (cfg.mode == TCPU_PWM) || (cfg.mode == TCPU_PWM_PR) || (cfg.mode == TCPU_PWM_DT);

		// Stop wins over start in the same cycle
		if (ev[`TCPU_EV_START])
			next_s.running = 1'b1;
		if (ev[`TCPU_EV_STOP])
			next_s.running = 1'b0;

		// Prescaler runs only while the unit is running, whatever the count event
		if (s.running) begin
			if (s.presc_cnt >= presc_lim(cfg.presc)) begin
				next_s.presc_cnt = '0; // R03
				tick = 1'b1;
			end else begin
				next_s.presc_cnt = s.presc_cnt + 1'b1;
			end
		end

		// Step source and direction
		if (cfg.mode == TCPU_QUAD) begin
			step = s.running && ((phase_a ^ s.qa_prev) ^ (phase_b ^ s.qb_prev)); // R14
			step_up = phase_a ^ s.qb_prev; // R14
		end else begin
			step = tick && ev[`TCPU_EV_COUNT];
			case (cfg.dir)
				TCPU_DOWN: step_up = 1'b0; // R02
				TCPU_UPDOWN: step_up = ~s.going_down; // R02
				default: step_up = 1'b1;
			endcase
		end

		// Counter motion with wrap at period and zero
		if (step) begin
			if (cfg.mode == TCPU_PWM_PR) begin
				next_s.count = lfsr_step(s.count); // R01
				if (s.count == s.per) begin
					next_s.flags.ovf = 1'b1;
					wrap = 1'b1;
				end
			end else if (step_up) begin
				if (s.count >= s.per) begin
					next_s.flags.ovf = 1'b1; // R05
					wrap = 1'b1;
					if (cfg.dir == TCPU_UPDOWN && cfg.mode != TCPU_QUAD) begin
						next_s.going_down = 1'b1;
						next_s.count = s.count - 1'b1;
					end else begin
						next_s.count = '0;
					end
				end else begin
					next_s.count = s.count + 1'b1;
				end
			end else begin
				if (s.count == '0) begin
					next_s.flags.unf = 1'b1; // R05
					wrap = 1'b1;
					if (cfg.dir == TCPU_UPDOWN && cfg.mode != TCPU_QUAD) begin
						next_s.going_down = 1'b0;
						next_s.count = {{(W-1){1'b0}}, 1'b1};
					end else begin
						next_s.count = period_after_swap(s.per_pend, s.per_buf, s.per); // R15
					end
				end else begin
					next_s.count = s.count - 1'b1;
				end
			end
		end
		next_s.flags.tc_irq = wrap; // R06

		// Compare match on every step that lands on the compare value, except in capture mode
		if (step && cfg.mode != TCPU_TIMER_CAP && next_s.count == s.cmp) begin
			next_s.flags.cc = 1'b1; // R08
			next_s.flags.cc_irq = 1'b1; // R08
		end

		// Reload restarts the period from its start
		if (ev[`TCPU_EV_RELOAD]) begin
			if (cfg.dir == TCPU_DOWN)
				next_s.count = period_after_swap(s.per_pend, s.per_buf, s.per); // R15
			else
				next_s.count = '0;
			next_s.going_down = 1'b0;
			next_s.presc_cnt = '0;
		end

		// Capture copies the live count
		if (cfg.mode == TCPU_TIMER_CAP && ev[`TCPU_EV_CAPTURE]) begin
			next_s.capture = s.count; // R07
			next_s.flags.cc = 1'b1; // R07
			next_s.flags.cc_irq = 1'b1; // R07
		end

		// Buffer swap only at period boundaries, so a period is never cut short
		swap = wrap || ev[`TCPU_EV_RELOAD];
		if (swap && s.cmp_pend) begin
			next_s.cmp = s.cmp_buf; // R15
			next_s.cmp_pend = 1'b0;
		end
		if (swap && s.per_pend) begin
			next_s.per = s.per_buf; // R15
			next_s.per_pend = 1'b0;
		end
		// Writes go to the buffers only; a write in a swap cycle stays pending
		if (cmp_buf_wr) begin
			next_s.cmp_buf = cmp_buf_data; // R04
			next_s.cmp_pend = 1'b1;
		end
		if (per_buf_wr) begin
			next_s.per_buf = per_buf_data; // R04
			next_s.per_pend = 1'b1;
		end

		// Waveform and dead-time delay on each rising edge of either side
		raw = is_pwm && (s.count < s.cmp);
		next_s.raw_prev = raw;
		if (raw != s.raw_prev)
			next_s.dt_cnt = '0;
		else if (s.dt_cnt != cfg.dead_time)
			next_s.dt_cnt = s.dt_cnt + 1'b1;
		dt_done = (cfg.mode != TCPU_PWM_DT) || (raw == s.raw_prev && s.dt_cnt == cfg.dead_time);
		next_s.pwm = raw && dt_done; // R01
		next_s.pwm_n = is_pwm && !raw && dt_done; // R09

		// Kill overrides whatever the waveform logic wants
		if (kill) begin
			next_s.pwm = cfg.kill_lvl; // R12
			next_s.pwm_n = cfg.kill_lvl_n; // R12
		end
	end

	// State register; clk_en low freezes everything
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.running <= `TCPU_RST_RUNNING;
			s.pwm <= `TCPU_RST_PWM;
			s.cmp_pend <= `TCPU_RST_PEND;
			s.per_pend <= `TCPU_RST_PEND;
		end else if (clk_en) begin
			s <= next_s;
		end
	end

	// Outputs straight from state flops
	assign flags = s.flags;
	assign pwm_out = s.pwm;
	assign pwm_out_n = s.pwm_n;
	assign running = s.running;
	assign count = s.count;
	assign capture = s.capture;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_kill_force: assert property (clk_en && kill |=> pwm_out == $past(cfg.kill_lvl) && pwm_out_n == $past(cfg.kill_lvl_n)) else $error("kill did not force outputs"); // R12
	a_pwm_complement: assert property (clk_en && !kill && cfg.mode == TCPU_PWM |=> pwm_out_n == !pwm_out) else $error("pwm complement broken"); // R09
	a_capture_copy: assert property (clk_en && cfg.mode == TCPU_TIMER_CAP && ev[`TCPU_EV_CAPTURE] |=> capture == $past(count) && flags.cc_irq) else $error("capture not taken"); // R07
	a_compare_irq: assert property (clk_en && step && cfg.mode == TCPU_TIMER_CMP && next_s.count == s.cmp |=> flags.cc && flags.cc_irq) else $error("compare match missed"); // R08
	a_up_overflow: assert property (flags.ovf && $past(cfg.dir) == TCPU_UP && $past(cfg.mode) == TCPU_TIMER_CMP && !$past(ev[`TCPU_EV_RELOAD]) |-> count == '0 && flags.tc_irq) else $error("overflow wrap wrong"); // R06
	a_presc_bound: assert property (clk_en && s.running // R03
		&& s.presc_cnt >= presc_lim(cfg.presc) |=> s.presc_cnt == '0)
		else $error("prescaler overrun");
	a_cmp_stable: assert property (clk_en && !wrap && !ev[`TCPU_EV_RELOAD] |=> $stable(s.cmp) && $stable(s.per)) else $error("active value changed mid-period"); // R15
	a_down_step: assert property (clk_en && step && cfg.dir == TCPU_DOWN && cfg.mode == TCPU_TIMER_CMP && !wrap && !ev[`TCPU_EV_RELOAD] |=> count == $past(count) - 1'b1) else $error("down count wrong"); // R02
	a_quad_up: assert property (clk_en && cfg.mode == TCPU_QUAD && step && step_up && s.count < s.per && !ev[`TCPU_EV_RELOAD] |=> count == $past(count) + 1'b1) else $error("quadrature up count wrong"); // R14
	a_start_src: assert property (clk_en && cfg.edge_sel[`TCPU_EV_START] == TCPU_LEVEL && trig_in[cfg.src_sel[`TCPU_EV_START]] && !ev[`TCPU_EV_STOP] |=> running) else $error("start source ignored"); // R10

	// Period boundary, dead band and buffer write; the new period must land with the wrap
	a_down_wrap: assert property (clk_en && step && cfg.mode == TCPU_TIMER_CMP // R06
		&& cfg.dir == TCPU_DOWN && s.count == '0 && !ev[`TCPU_EV_RELOAD]
		|=> flags.unf && flags.tc_irq && count == s.per) else $error("underflow reload wrong");
	a_dead_gap: assert property (clk_en && !kill && cfg.mode == TCPU_PWM_DT // R01
		&& raw != s.raw_prev |=> !pwm_out && !pwm_out_n) else $error("dead time gap missing");
	a_buf_write: assert property (clk_en && cmp_buf_wr // R04
		|=> s.cmp_pend && s.cmp_buf == $past(cmp_buf_data)) else $error("buffer write lost");

	c_overflow: cover property (flags.ovf);
	c_capture: cover property (flags.cc && cfg.mode == TCPU_TIMER_CAP);
	c_kill: cover property (clk_en && kill);
	c_swap: cover property (clk_en && swap && s.cmp_pend);
	c_quad_step: cover property (clk_en && cfg.mode == TCPU_QUAD && step);

endmodule : tcpu_unit

// File: bench/tcpu_quad_enc.sv
// Quadrature encoder model driving the two phase inputs of the timer unit.
// Assumes the bench changes step and fwd away from the rising clock edge.
`timescale 1ns/100ps

module tcpu_quad_enc (
	input wire logic clk,
	input wire logic step,
	input wire logic fwd,
	output logic phase_a,
	output logic phase_b
);
	logic [1:0] pos = 2'h0;

	// One position per clock while step is high; NBA keeps the move after sampling
	always @(posedge clk) begin
		if (step) begin
			pos <= fwd ? pos + 2'h1 : pos - 2'h1;
		end
	end

	// Gray code, so only one phase changes per step
	assign phase_a = pos[1] ^ pos[0];
	assign phase_b = pos[1];
endmodule : tcpu_quad_enc

// File: bench/timer_counter_pwm_unit_bench.sv
// Self-checking bench for a narrow timer/counter/PWM unit instance.
// Assumes trigger line i feeds event slot i and line 3 gates counting.
`timescale 1ns/100ps

module timer_counter_pwm_unit_bench import tcpu_pkg::*;;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	tcpu_cfg_t cfg;
	logic [15:0] trig_in = 16'h0008;
	logic kill = 1'h0;
	logic cmp_buf_wr = 1'h0;
	logic per_buf_wr = 1'h0;
	logic [15:0] cmp_d = 16'h0000;
	logic [15:0] per_d = 16'h0000;
	logic [15:0] count, capture, c;
	logic step = 1'h0;
	logic fwd = 1'h1;
	logic phase_a, phase_b, pwm_out, pwm_out_n, running;
	tcpu_flags_t flags;
	int n_errors = 0;
	int tests_run = 0;
	int ncc = 0;
	int h, hn;

	tcpu_unit #(.W(16), .N_TRIG(16)) uut (.clk(clk), .resetn(resetn), .clk_en(1'h1),
		.cfg(cfg), .trig_in(trig_in), .phase_a(phase_a), .phase_b(phase_b),
		.kill(kill), .cmp_buf_wr(cmp_buf_wr), .cmp_buf_data(cmp_d),
		.per_buf_wr(per_buf_wr), .per_buf_data(per_d), .flags(flags),
		.pwm_out(pwm_out), .pwm_out_n(pwm_out_n), .running(running),
		.count(count), .capture(capture));

	tcpu_quad_enc enc (.clk(clk), .step(step), .fwd(fwd), .phase_a(phase_a),
		.phase_b(phase_b));

	// Clock; compare pulses counted here since their exact cycle is open
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		if (flags.cc === 1'h1) ncc <= ncc + 1;
	end

	task give_verdict;
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task nx(input int k);
		repeat (k) @(negedge clk);
	endtask : nx

	// Edge on one trigger line; stop reacts to the falling half
	task pulse(input int i);
		trig_in[i] = 1'h1;
		nx(1);
		trig_in[i] = 1'h0;
		nx(1);
	endtask : pulse

	task load(input logic [15:0] p, input logic [15:0] m);
		per_d = p;
		cmp_d = m;
		per_buf_wr = 1'h1;
		cmp_buf_wr = 1'h1;
		nx(1);
		per_buf_wr = 1'h0;
		cmp_buf_wr = 1'h0;
		pulse(1);
	endtask : load

	// Stop, reconfigure, reload and restart; cfg only moves while stopped
	task setup(input tcpu_mode_t m, input tcpu_dir_t d, input logic [2:0] p,
		input logic [15:0] per);
		pulse(2);
		cfg.mode = m;
		cfg.dir = d;
		cfg.presc = p;
		load(per, 16'h0002);
		pulse(0);
	endtask : setup

	// Cycles up to the next terminal count, bounded
	task till_tc(input bit ck, input int e);
		int k;
		k = 0;
		do begin
			nx(1);
			k++;
		end while (flags.tc_irq !== 1'h1 && k < 2000);
		if (ck) chk(k, e);
	endtask : till_tc

	task pwm_run(input int eh, input int ehn);
		h = 0;
		hn = 0;
		nx(6);
		repeat (12) begin
			nx(1);
			h += pwm_out;
			hn += pwm_out_n;
		end
		chk(h, eh);
		chk(hn, ehn);
	endtask : pwm_run

	// Watchdog, far beyond the few thousand cycles the tests take
	initial begin
		#400000;
		n_errors++;
		give_verdict;
	end

	initial begin
		cfg = '0;
		for (int i = 0; i < 5; i++) cfg.src_sel[i] = 4'(i);
		cfg.edge_sel[3] = TCPU_LEVEL;
		cfg.edge_sel[2] = TCPU_FALL;
		nx(3);
		resetn = 1'h1;
		load(16'h0003, 16'h0002);
		pulse(0);
		chk(count, 1);
		nx(1);
		chk(count, 2);
		nx(1);
		chk(count, 3);
		nx(1);
		chk(count, 0);
		chk({flags.ovf, flags.unf, flags.tc_irq}, 3'h5);
		chk(ncc, 1);
		per_d = 16'h0005;
		per_buf_wr = 1'h1;
		nx(1);
		per_buf_wr = 1'h0;
		till_tc(1, 3);
		till_tc(1, 6);
		trig_in[2] = 1'h1;
		nx(2);
		chk(running, 1);
		trig_in[2] = 1'h0;
		nx(2);
		chk(running, 0);
		for (int k = 0; k < 8; k++) begin
			setup(TCPU_TIMER_CMP, TCPU_UP, 3'(k), 16'h0005);
			till_tc(0, 0);
			till_tc(1, 6 << k);
		end
		setup(TCPU_TIMER_CMP, TCPU_DOWN, 3'h0, 16'h0005);
		till_tc(0, 0);
		till_tc(1, 6);
		chk({flags.ovf, flags.unf}, 2'h1);
		setup(TCPU_TIMER_CMP, TCPU_UPDOWN, 3'h0, 16'h0005);
		till_tc(0, 0);
		till_tc(1, 5);
		setup(TCPU_TIMER_CAP, TCPU_UP, 3'h0, 16'h0005);
		nx(2);
		c = count;
		trig_in[4] = 1'h1;
		nx(1);
		chk(capture, c);
		chk(flags.cc_irq, 1);
		trig_in[4] = 1'h0;
		setup(TCPU_PWM, TCPU_UP, 3'h0, 16'h0005);
		pwm_run(4, 8);
		cfg.kill_lvl = 1'h1;
		cfg.kill_lvl_n = 1'h1;
		kill = 1'h1;
		repeat (8) begin
			nx(1);
			chk({pwm_out, pwm_out_n}, 2'h3);
		end
		kill = 1'h0;
		setup(TCPU_PWM_DT, TCPU_UP, 3'h0, 16'h0005);
		pwm_run(2, 6);
		setup(TCPU_PWM_PR, TCPU_UP, 3'h0, 16'h0004);
		till_tc(1, 3);
		chk(count, 16'h0008);
		setup(TCPU_QUAD, TCPU_UP, 3'h0, 16'h0064);
		nx(2);
		c = count;
		step = 1'h1;
		nx(4);
		step = 1'h0;
		nx(3);
		chk(count, c + 16'h0004);
		fwd = 1'h0;
		step = 1'h1;
		nx(2);
		step = 1'h0;
		nx(3);
		chk(count, c + 16'h0002);
		pulse(2);
		chk(running, 0);
		cfg.edge_sel[0] = TCPU_LEVEL;
		trig_in[0] = 1'h1;
		nx(2);
		chk(running, 1);
		trig_in[0] = 1'h0;
		give_verdict;
	end
endmodule : timer_counter_pwm_unit_bench
